// ### src/amp_cfg_pkg.sv
// constants for the amplifier configuration register bank
package amp_cfg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // register addresses
    localparam logic [7:0] OFF_CH3_INPUT_SELECT       = 8'h04;
    localparam logic [7:0] OFF_CH1_GAIN_CODE          = 8'h06;
    localparam logic [7:0] OFF_CH2_GAIN_CODE          = 8'h07;
    localparam logic [7:0] OFF_CH3_GAIN_CODE          = 8'h08;
    localparam logic [7:0] OFF_AMP_SPEED_MODE         = 8'h09;
    localparam logic [7:0] OFF_AMP_DAC_POWER_ENABLE   = 8'h11;
    // reset values
    localparam logic [7:0] RST_CH3_INPUT_SELECT       = 8'h00;
    localparam logic [7:0] RST_GAIN_CODE              = 8'h00;
    localparam logic [7:0] RST_AMP_SPEED_MODE         = 8'h00;
    localparam logic [7:0] RST_AMP_DAC_POWER_ENABLE   = 8'h00;
    // writable bit masks
    localparam logic [7:0] MASK_GAIN_CODE             = 8'h1f;
    localparam logic [7:0] MASK_AMP_SPEED_MODE        = 8'h3f;
    localparam logic [7:0] MASK_CH3_INPUT_SELECT      = 8'hff;
    localparam logic [7:0] MASK_AMP_DAC_POWER_ENABLE  = 8'hff;
    // field positions
    localparam int GAIN_LSB         = 0;
    localparam int GAIN_W           = 5;
    localparam int SPEED_LSB        = 0;
    localparam int SPEED_W          = 2;
    localparam int NONINV_SRC_LSB   = 0;
    localparam int INV_SRC_LSB      = 4;
    localparam int SRC_W            = 3;
    localparam int AMP_EN_LSB       = 0;
    localparam int AMP_EN_W         = 3;
    localparam int CONV_EN_LSB      = 4;
    localparam int CONV_EN_W        = 4;
    localparam int INST_AMP_GAIN    = 3;
    localparam logic [7:0] VAL_INST_AMP_GAIN = 8'h03;

    typedef enum logic [1:0] {
        SPEED_HIGH = 2'b00,
        SPEED_MID2 = 2'b01,
        SPEED_MID1 = 2'b10,
        SPEED_LOW  = 2'b11
    } speed_mode_t;

    typedef enum logic [2:0] {
        SRC_PIN_A     = 3'b000,
        SRC_PIN_B     = 3'b001,
        SRC_CH1_OUT   = 3'b010,
        SRC_CH2_OUT   = 3'b011,
        SRC_CONV3_REF = 3'b100
    } ch3_src_t;
endpackage

// ### src/amp_cfg_reg.sv
// one masked 8-bit control register with its own write strobe
`timescale 1ns/10ps
`default_nettype none
module amp_cfg_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK   = 8'hff
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // write side
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    // stored value
    output logic      [7:0] value
);
    logic [7:0] value_r;

    // masked bits never store, so they read as zero
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            value_r <= RESET_VAL;
        end else if (wr_en) begin
            value_r <= wr_data & WR_MASK;
        end
    end

    assign value = value_r;
endmodule
`default_nettype wire

// ### src/amplifier_config_regs.sv
// register bank steering three configurable amplifier channels
`timescale 1ns/10ps
`default_nettype none
module amplifier_config_regs
    import amp_cfg_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset,
    // register port from the serial control interface
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic      [DATA_W-1:0] reg_rdata,
    output logic                   reg_hit,
    // analog control outputs
    output logic      [GAIN_W-1:0] ch1_gain,
    output logic      [GAIN_W-1:0] ch2_gain,
    output logic      [GAIN_W-1:0] ch3_gain,
    output speed_mode_t            amp_speed,
    output logic      [SRC_W-1:0]  ch3_noninv_src,
    output logic      [SRC_W-1:0]  ch3_inv_src,
    output logic                   ch1_power_on,
    output logic                   ch2_power_on,
    output logic                   ch3_power_on,
    output logic      [CONV_EN_W-1:0] conv_power_on,
    output logic                   inst_amp_ready
);
    ////////////////////////////////////////////////////////////////////////
    // address decode
    logic       we_sel;
    logic       we_g1;
    logic       we_g2;
    logic       we_g3;
    logic       we_spd;
    logic       we_pwr;
    logic [7:0] sel_q;
    logic [7:0] g1_q;
    logic [7:0] g2_q;
    logic [7:0] g3_q;
    logic [7:0] spd_q;
    logic [7:0] pwr_q;
    logic [7:0] rdata_nxt;
    logic       hit_nxt;
    logic [7:0] rdata_r;

    // register port writes land in one cycle
    assign we_sel = reg_wr && (reg_addr == OFF_CH3_INPUT_SELECT);
    assign we_g1  = reg_wr && (reg_addr == OFF_CH1_GAIN_CODE);
    assign we_g2  = reg_wr && (reg_addr == OFF_CH2_GAIN_CODE);
    assign we_g3  = reg_wr && (reg_addr == OFF_CH3_GAIN_CODE);
    assign we_spd = reg_wr && (reg_addr == OFF_AMP_SPEED_MODE);
    assign we_pwr = reg_wr && (reg_addr == OFF_AMP_DAC_POWER_ENABLE);

    ////////////////////////////////////////////////////////////////////////
    // storage
    // source select keeps bits 7 and 3 too
    amp_cfg_reg #(
        .RESET_VAL (RST_CH3_INPUT_SELECT),
        .WR_MASK   (MASK_CH3_INPUT_SELECT)
    ) u_sel (
        .ref_clk (ref_clk),
        .reset   (reset),
        .wr_en   (we_sel),
        .wr_data (reg_wdata),
        .value   (sel_q)
    );

    // gain upper bits masked off
    amp_cfg_reg #(
        .RESET_VAL (RST_GAIN_CODE),
        .WR_MASK   (MASK_GAIN_CODE)
    ) u_g1 (
        .ref_clk (ref_clk),
        .reset   (reset),
        .wr_en   (we_g1),
        .wr_data (reg_wdata),
        .value   (g1_q)
    );

    amp_cfg_reg #(
        .RESET_VAL (RST_GAIN_CODE),
        .WR_MASK   (MASK_GAIN_CODE)
    ) u_g2 (
        .ref_clk (ref_clk),
        .reset   (reset),
        .wr_en   (we_g2),
        .wr_data (reg_wdata),
        .value   (g2_q)
    );

    amp_cfg_reg #(
        .RESET_VAL (RST_GAIN_CODE),
        .WR_MASK   (MASK_GAIN_CODE)
    ) u_g3 (
        .ref_clk (ref_clk),
        .reset   (reset),
        .wr_en   (we_g3),
        .wr_data (reg_wdata),
        .value   (g3_q)
    );

    // bits 5..2 store but drive nothing; 7..6 masked
    amp_cfg_reg #(
        .RESET_VAL (RST_AMP_SPEED_MODE),
        .WR_MASK   (MASK_AMP_SPEED_MODE)
    ) u_spd (
        .ref_clk (ref_clk),
        .reset   (reset),
        .wr_en   (we_spd),
        .wr_data (reg_wdata),
        .value   (spd_q)
    );

    // bit 3 stored as written; zeroing it is the host's job
    amp_cfg_reg #(
        .RESET_VAL (RST_AMP_DAC_POWER_ENABLE),
        .WR_MASK   (MASK_AMP_DAC_POWER_ENABLE)
    ) u_pwr (
        .ref_clk (ref_clk),
        .reset   (reset),
        .wr_en   (we_pwr),
        .wr_data (reg_wdata),
        .value   (pwr_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // read path
    always_comb begin
        rdata_nxt = 8'h00;
        hit_nxt   = 1'b1;
        if (reg_addr == OFF_CH3_INPUT_SELECT) begin
            rdata_nxt = sel_q;
        end else if (reg_addr == OFF_CH1_GAIN_CODE) begin
            rdata_nxt = g1_q;
        end else if (reg_addr == OFF_CH2_GAIN_CODE) begin
            rdata_nxt = g2_q;
        end else if (reg_addr == OFF_CH3_GAIN_CODE) begin
            rdata_nxt = g3_q;
        end else if (reg_addr == OFF_AMP_SPEED_MODE) begin
            rdata_nxt = spd_q;
        end else if (reg_addr == OFF_AMP_DAC_POWER_ENABLE) begin
            rdata_nxt = pwr_q;
        end else begin
            hit_nxt = 1'b0;
        end
    end

    // read data registered; unmapped addresses return zero
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_hit   = hit_nxt;

    ////////////////////////////////////////////////////////////////////////
    // analog controls, driven raw even for prohibited codes
    // code meaning depends on the analog configuration, not on this bank
    assign ch1_gain = g1_q[GAIN_LSB +: GAIN_W];
    assign ch2_gain = g2_q[GAIN_LSB +: GAIN_W];
    assign ch3_gain = g3_q[GAIN_LSB +: GAIN_W];
    assign amp_speed = speed_mode_t'(spd_q[SPEED_LSB +: SPEED_W]);
    assign ch3_noninv_src = sel_q[NONINV_SRC_LSB +: SRC_W];
    assign ch3_inv_src    = sel_q[INV_SRC_LSB +: SRC_W];
    assign ch1_power_on = pwr_q[AMP_EN_LSB];
    assign ch2_power_on = pwr_q[AMP_EN_LSB + 1];
    assign ch3_power_on = pwr_q[AMP_EN_LSB + 2];
    assign conv_power_on = pwr_q[CONV_EN_LSB +: CONV_EN_W];

    // status hint: all three channels on with ch1/ch2 at fixed gain
    assign inst_amp_ready = (g1_q == VAL_INST_AMP_GAIN)
                         && (g2_q == VAL_INST_AMP_GAIN)
                         && (&pwr_q[AMP_EN_LSB +: AMP_EN_W]);

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks
    // storage cells and byte offsets are fixed at eight bits
    if (DATA_W != 8 || ADDR_W != 8) begin : g_bad_bus_width
        $error("register port must be eight bits wide");
    end

    // each field slice must sit inside its register
    if (GAIN_LSB + GAIN_W > DATA_W) begin : g_bad_gain_field
        $error("gain field runs past the register");
    end

    if (SPEED_LSB + SPEED_W > DATA_W) begin : g_bad_speed_field
        $error("speed field runs past the register");
    end

    // the speed enum is two bits wide, a wider field would be cut
    if (SPEED_W != 2) begin : g_bad_speed_width
        $error("speed field must match the speed mode type");
    end

    // both source fields share one register and must not overlap
    if (NONINV_SRC_LSB + SRC_W > INV_SRC_LSB
        || INV_SRC_LSB + SRC_W > DATA_W) begin : g_bad_src_fields
        $error("source fields overlap or run past the register");
    end

    // one enable per channel; the channel outputs index bits 0..2
    if (AMP_EN_W != 3
        || AMP_EN_LSB + AMP_EN_W > CONV_EN_LSB
        || CONV_EN_LSB + CONV_EN_W > DATA_W) begin : g_bad_power_fields
        $error("power enable fields do not fit the register");
    end
endmodule
`default_nettype wire

// ### verification/amp_host_model.sv
// host controller model driving the register port of the bank
`timescale 1ns/10ps
`default_nettype none
module amp_host_model (
    // clock
    input  wire logic       ref_clk,
    // register port
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    // callers choose gain codes 00..11h in bits 4..0; the bench also sets bits 7..5 on two of them
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = (a == 8'h11) ? (d & 8'hf7) : d;
        @(posedge ref_clk);
        #1;
        reg_wr    = 1'b0;
        // idle data is scrambled so no stale value can pass for a write
        reg_wdata = ~reg_wdata;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_rd   = 1'b1;
        reg_addr = a;
        @(posedge ref_clk);
        #1;
        reg_rd = 1'b0;
        d      = reg_rdata;
    endtask
    task automatic inst_start();
        wr(8'h06, 8'h03);
        wr(8'h07, 8'h03);
        wr(8'h11, 8'h07);
    endtask
    task automatic inst_stop();
        wr(8'h11, 8'h00);
    endtask
endmodule
`default_nettype wire

// ### verification/amp_cfg_monitor.sv
// checker for the amplifier configuration register bank
`timescale 1ns/10ps
`default_nettype none
module amp_cfg_monitor
    import amp_cfg_pkg::*;
(
    // clock and reset
    input wire logic                 ref_clk,
    input wire logic                 reset,
    // register port
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [ADDR_W-1:0]    reg_addr,
    input wire logic [DATA_W-1:0]    reg_wdata,
    input wire logic [DATA_W-1:0]    reg_rdata,
    input wire logic                 reg_hit,
    // control outputs
    input wire logic [GAIN_W-1:0]    ch1_gain,
    input wire logic [GAIN_W-1:0]    ch2_gain,
    input wire logic [GAIN_W-1:0]    ch3_gain,
    input wire speed_mode_t          amp_speed,
    input wire logic [SRC_W-1:0]     ch3_noninv_src,
    input wire logic [SRC_W-1:0]     ch3_inv_src,
    input wire logic                 ch1_power_on,
    input wire logic                 ch2_power_on,
    input wire logic                 ch3_power_on,
    input wire logic [CONV_EN_W-1:0] conv_power_on,
    input wire logic                 inst_amp_ready
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_wr(logic [7:0] a);
        reg_wr && reg_addr == a;
    endsequence
    sequence s_rd(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    chk_ch1_gain_write: assert property (
        s_wr(OFF_CH1_GAIN_CODE) |=> ch1_gain == $past(reg_wdata[4:0]))
        else $error("ch1 gain differs from written code");
    chk_ch3_gain_write: assert property (
        s_wr(OFF_CH3_GAIN_CODE) |=> ch3_gain == $past(reg_wdata[4:0]))
        else $error("ch3 gain differs from written code");
    chk_speed_write: assert property (
        s_wr(OFF_AMP_SPEED_MODE) |=> amp_speed == $past(reg_wdata[1:0]))
        else $error("speed mode differs from written field");
    chk_src_write: assert property (
        s_wr(OFF_CH3_INPUT_SELECT) |=> ch3_noninv_src == $past(reg_wdata[2:0])
        && ch3_inv_src == $past(reg_wdata[6:4]))
        else $error("ch3 source fields differ from write");
    chk_power_hold: assert property (
        !(reg_wr && reg_addr == OFF_AMP_DAC_POWER_ENABLE)
        |=> $stable({ch3_power_on,
        ch2_power_on, ch1_power_on, conv_power_on}))
        else $error("power enables moved without a write");
    chk_gain_read_top: assert property (
        s_rd(OFF_CH2_GAIN_CODE) |=> reg_rdata[7:5] == 3'b000
        && reg_rdata[4:0] == $past(ch2_gain))
        else $error("ch2 gain readback wrong");
    chk_speed_read_top: assert property (
        s_rd(OFF_AMP_SPEED_MODE) |=> reg_rdata[7:6] == 2'b00
        && reg_rdata[1:0] == $past(amp_speed))
        else $error("speed readback wrong");
    chk_unmapped_read: assert property (
        reg_rd && !reg_hit |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_inst_ready: assert property (
        inst_amp_ready == (ch1_gain == 5'h03 && ch2_gain == 5'h03
        && ch1_power_on && ch2_power_on && ch3_power_on))
        else $error("instrumentation ready flag wrong");
endmodule
bind amplifier_config_regs amp_cfg_monitor i_mon (.ref_clk, .reset,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit,
    .ch1_gain, .ch2_gain, .ch3_gain, .amp_speed, .ch3_noninv_src,
    .ch3_inv_src, .ch1_power_on, .ch2_power_on, .ch3_power_on,
    .conv_power_on, .inst_amp_ready);
`default_nettype wire

// ### verification/tb_amplifier_config_regs.sv
// self-checking bench for the amplifier configuration register bank
`timescale 1ns/10ps
`default_nettype none
module tb_amplifier_config_regs
    import amp_cfg_pkg::*;
;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] q;
        logic       h;
    } row_t;
    logic        ref_clk, reset, reg_wr, reg_rd, reg_hit, inst_amp_ready;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, q;
    logic [4:0]  ch1_gain, ch2_gain, ch3_gain;
    speed_mode_t amp_speed;
    logic [2:0]  ch3_noninv_src, ch3_inv_src;
    logic        ch1_power_on, ch2_power_on, ch3_power_on;
    logic [3:0]  conv_power_on;
    logic [30:0] outs;
    int          err_count = 0;
    int          samples_checked = 0;
    // mapped rows first: the reset pass reads rows 0..5
    // gain rows keep the code legal; the ch1 and ch2 gain rows also set bits 7..5 to test the mask
    row_t        rows [7] = '{'{8'h04, 8'hff, 8'hff, 1'b1},
        '{8'h06, 8'hf1, 8'h11, 1'b1}, '{8'h07, 8'he3, 8'h03, 1'b1},
        '{8'h08, 8'h11, 8'h11, 1'b1}, '{8'h09, 8'hff, 8'h3f, 1'b1},
        '{8'h11, 8'hff, 8'hf7, 1'b1}, '{8'h05, 8'haa, 8'h00, 1'b0}};
    assign outs = {ch1_gain, ch2_gain, ch3_gain, amp_speed, ch3_noninv_src,
        ch3_inv_src, ch3_power_on, ch2_power_on, ch1_power_on, conv_power_on,
        inst_amp_ready};
    amplifier_config_regs i_dut (.ref_clk, .reset, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .ch1_gain, .ch2_gain,
        .ch3_gain, .amp_speed, .ch3_noninv_src, .ch3_inv_src, .ch1_power_on,
        .ch2_power_on, .ch3_power_on, .conv_power_on, .inst_amp_ready);
    amp_host_model i_host (.ref_clk, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata);
    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask
    task automatic stop_test();
        if (err_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // hang guard, far beyond the length of the sequence below
    initial begin
        #200000;
        err_count++;
        stop_test();
    end
    initial begin
        reset = 1'b1;
        repeat (10) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        chk("outputs after reset", 32'h0000_0000, {1'b0, outs});
        for (int i = 0; i < 6; i++) begin
            i_host.rd(rows[i].a, q);
            chk("reset value", 32'h0000_0000, {24'h0, q});
        end
        foreach (rows[i]) begin
            i_host.wr(rows[i].a, rows[i].d);
            i_host.rd(rows[i].a, q);
            chk("readback", {24'h0, rows[i].q}, {24'h0, q});
            chk("hit", {31'h0, rows[i].h}, {31'h0, reg_hit});
        end
        chk("fields", {1'b0, 5'h11, 5'h03, 5'h11, 2'b11, 6'h3f, 3'h7, 4'hf,
            1'b0}, {1'b0, outs});
        for (int m = 0; m < 4; m++) begin
            i_host.wr(8'h09, 8'h3c | 8'(m));
            chk("speed mode", 32'(m), {30'h0, amp_speed});
        end
        for (int s = 0; s < 5; s++) begin
            i_host.wr(8'h04, 8'h88 | 8'(s) | 8'((4 - s) << 4));
            chk("noninv source", 32'(s), {29'h0, ch3_noninv_src});
            chk("inv source", 32'(4 - s), {29'h0, ch3_inv_src});
        end
        i_host.inst_start();
        chk("inst ready", 32'h0000_0001, {31'h0, inst_amp_ready});
        i_host.inst_stop();
        chk("amp enables", 32'h0000_0000, {28'h0, ch3_power_on, ch2_power_on,
            ch1_power_on, inst_amp_ready});
        @(posedge ref_clk);
        #1;
        reset = 1'b1;
        @(posedge ref_clk);
        #1;
        chk("outputs in reset", 32'h0000_0000, {1'b0, outs});
        reset = 1'b0;
        // select last held 8ch, so bits 7 and 3 must be cleared as well
        i_host.rd(OFF_CH3_INPUT_SELECT, q);
        chk("select after reset", 32'h0000_0000, {24'h0, q});
        stop_test();
    end
endmodule
`default_nettype wire
